/* File: hdl/adc_iface_consts.vh */
// Constants shared by the converter interface and its result queue.
// Assumes it is included by bare name from files under hdl/.
`ifndef ADC_IFACE_CONSTS_VH
`define ADC_IFACE_CONSTS_VH
// Output format and serial clock selection (two-bit strap code).
`define FMT_BYTE_GATED  2'h0
`define FMT_BYTE_CONT   2'h1
`define FMT_WORD        2'h2
// Result and serial word sizes.
`define RES_BITS        12
`define SER_BITS        16
`define LEAD_ZERO_BITS  4
`define BYTE_BITS       8
`define SER_CNT_W       5
`define SER_CNT_LAST    5'h10
// Queue sizing.
`define QUEUE_DEPTH     4
`define QUEUE_AW        2
// Reset values.
`define RES_RESET       12'h000
`define SER_RESET       16'h0000
`endif

/* File: hdl/result_queue.v */
// Small first-in first-out queue of conversion results held in flip-flops.
// Assumes one clock and an asynchronous active-low reset shared with its user.
`timescale 1ns/10ps
`default_nettype none
module result_queue #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q        <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/adc_host_interface.v */
// Digital host interface of a 12-bit sampling converter: start, done/wait, parallel and serial output.
// Assumes all pins come from outside the clk domain; the conversion clock is sampled like any pin.
// Summary of operation
// R01 - Mode 1: done line goes low after conversion.
// R02 - Host never reads while converting.
// R03 - Host may decode a write into start.
// R04 - Format strap 0 V selects byte output.
// R05 - Slow memory: first read waits for conversion.
// R06 - Only the first byte read waits.
// R07 - Serial lines are open drain, pull low.
// R08 - Gated clock: serial lines off when idle.
// R09 - First serial bit valid on first fall.
// R10 - Sixteen bits shift out during conversion.
// R11 - Strap -5 V: serial clock runs freely.
// R12 - Result is 12 bits, 4096 codes.
// R13 - Serial word: four zeros, then MSB first.
// R14 - Done line released on read falling edge.
// R15 - Byte read: low eight, or zero-padded high nibble.
// R16 - Slow memory: chip select with low byte starts.
`include "adc_iface_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module adc_host_interface #(
  parameter RES_W = `RES_BITS,
  parameter SER_W = `SER_BITS
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             conv_clk,
  input  wire [1:0]       format_select,
  input  wire             convert_start_n,
  input  wire             cs_n,
  input  wire             rd_n,
  input  wire             msb_or_byte_select_pin,
  input  wire [RES_W-1:0] sample_code,
  output reg  [RES_W-1:0] data_out,
  output reg              data_oe_n,
  output reg              busy_int_n,
  output reg              serial_clock_oe_n,
  output reg              serial_data_oe_n,
  output reg              serial_frame_strobe_oe_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_PUSH = 2'h2;

  // Two-stage synchronisers; stage one feeds stage two only.
  reg [6:0]       pin_meta_q;
  reg [6:0]       pin_q;
  reg [RES_W-1:0] code_meta_q;
  reg [RES_W-1:0] code_q;
  reg             cclk_prev_q;
  reg             cstart_prev_q;
  reg             cs_prev_q;
  wire            cclk_s   = pin_q[0];
  wire            cstart_s = pin_q[1];
  wire            cs_s     = pin_q[2];
  wire            rd_s     = pin_q[3];
  wire            hbs_s    = pin_q[4];
  wire [1:0]      fmt_s    = pin_q[6:5];
  wire            cclk_rise = cclk_s & ~cclk_prev_q;
  wire            cclk_fall = ~cclk_s & cclk_prev_q;

  reg [1:0]           state_q;
  reg [SER_W-1:0]     shift_q;
  reg [`SER_CNT_W-1:0] bit_cnt_q;
  reg                 bit_q;
  reg [RES_W-1:0]     held_q;
  reg [RES_W-1:0]     latch_q;
  reg                 fresh_q;
  reg                 slow_mode_q;
  reg                 read_seen_q;

  wire             q_in_ready;
  wire             q_out_valid;
  wire [RES_W-1:0] q_out_data;

  wire high_byte_select = hbs_s;
  wire rd_active   = ~cs_s & ~rd_s;
  wire converting  = (state_q != ST_IDLE);
  // A new start is refused while the queue is full, so results are never dropped.
  // The low phase of a start pulse looks like slow mode, so the rising edge alone decides here.
  wire start_fast  = cstart_s & ~cstart_prev_q & cs_s;
  wire start_slow  = ~cstart_s & ~cs_s & cs_prev_q & ~high_byte_select;  // R16
  wire start_go    = (state_q == ST_IDLE) & q_in_ready & (start_fast | start_slow);
  // The latch is refilled only outside a read, so bytes of one word never mix.
  // A slow-mode read is the exception: it is held waiting for exactly this result.
  wire latch_load  = q_out_valid & ~fresh_q & (~rd_active | slow_mode_q);
  wire data_ready  = ~converting & ~latch_load & ~q_out_valid;
  wire read_take   = rd_active & ~read_seen_q & ~converting & fresh_q;
  wire serial_fmt  = (fmt_s != `FMT_WORD);
  // The frame opens at the first shift, so no falling edge inside it comes before a valid bit.
  wire frame_on    = (state_q == ST_CONV) & (bit_cnt_q != {`SER_CNT_W{1'b0}});

  function [RES_W-1:0] read_word;
    input [1:0]       fmt;
    input             hbs;
    input [RES_W-1:0] word;
    begin
      if (fmt == `FMT_WORD) begin
        read_word = word;
      end else if (hbs) begin
        read_word = {{(RES_W-`LEAD_ZERO_BITS){1'b0}}, word[RES_W-1:`BYTE_BITS]};  // R15
      end else begin
        read_word = {{(RES_W-`BYTE_BITS){1'b0}}, word[`BYTE_BITS-1:0]};  // R15 R04
      end
    end
  endfunction

  result_queue #(
    .WIDTH (RES_W),
    .DEPTH (`QUEUE_DEPTH),
    .AW    (`QUEUE_AW)
  ) u_queue (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (state_q == ST_PUSH),
    .in_ready  (q_in_ready),
    .in_data   (held_q),
    .out_valid (q_out_valid),
    .out_ready (latch_load),
    .out_data  (q_out_data)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q    <= 7'h7E;
      pin_q         <= 7'h7E;
      code_meta_q   <= `RES_RESET;
      code_q        <= `RES_RESET;
      cclk_prev_q   <= 1'b0;
      cstart_prev_q <= 1'b1;
      cs_prev_q     <= 1'b1;
    end else begin
      pin_meta_q    <= {format_select, msb_or_byte_select_pin, rd_n, cs_n, convert_start_n, conv_clk};
      pin_q         <= pin_meta_q;
      code_meta_q   <= sample_code;
      code_q        <= code_meta_q;
      cclk_prev_q   <= cclk_s;
      cstart_prev_q <= cstart_s;
      cs_prev_q     <= cs_s;
    end
  end

  // Conversion engine: one serial bit per conversion clock period.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      shift_q     <= `SER_RESET;
      bit_cnt_q   <= {`SER_CNT_W{1'b0}};
      bit_q       <= 1'b1;
      held_q      <= `RES_RESET;
      slow_mode_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          bit_q <= 1'b1;
          if (start_go) begin
            held_q      <= code_q;  // R12
            shift_q     <= {{`LEAD_ZERO_BITS{1'b0}}, code_q};  // R13
            bit_cnt_q   <= {`SER_CNT_W{1'b0}};
            slow_mode_q <= start_slow;
            state_q     <= ST_CONV;
          end else if (~cstart_s & cs_s) begin
            slow_mode_q <= 1'b1;
          end else if (cstart_s) begin
            slow_mode_q <= 1'b0;
          end
        end
        ST_CONV: begin
          if (cclk_rise & (bit_cnt_q != `SER_CNT_LAST)) begin
            bit_q     <= shift_q[SER_W-1];  // R09 R10
            shift_q   <= {shift_q[SER_W-2:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + {{(`SER_CNT_W-1){1'b0}}, 1'b1};
          end else if (cclk_fall & (bit_cnt_q == `SER_CNT_LAST)) begin
            state_q <= ST_PUSH;  // R10
          end
        end
        ST_PUSH: begin
          bit_q   <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Output latch, done/wait line and parallel read path.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q     <= `RES_RESET;
      fresh_q     <= 1'b0;
      read_seen_q <= 1'b0;
      busy_int_n  <= 1'b1;
      data_out    <= `RES_RESET;
      data_oe_n   <= 1'b1;
    end else begin
      read_seen_q <= rd_active;
      if (latch_load) begin
        latch_q <= q_out_data;
        fresh_q <= 1'b1;  // R01
      end else if (read_take) begin
        fresh_q <= 1'b0;  // R14
      end
      if (slow_mode_q) begin
        busy_int_n <= ~(converting | ~data_ready);  // R05
      end else begin
        busy_int_n <= ~(fresh_q | latch_load);  // R01 R14
      end
      // In slow mode the first read holds off until the result lands; a later byte read drives at once if fresh_q is set, else one cycle after read_seen_q sets.
      if (rd_active & data_ready & (fresh_q | read_seen_q | ~slow_mode_q)) begin
        data_oe_n <= 1'b0;  // R05 R06
        data_out  <= read_word(fmt_s, high_byte_select, latch_q);  // R04 R15
      end else begin
        data_oe_n <= 1'b1;
        data_out  <= `RES_RESET;
      end
    end
  end

  // Serial lines only ever pull low; an enable low means the pin is pulled down.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clock_oe_n        <= 1'b1;
      serial_data_oe_n         <= 1'b1;
      serial_frame_strobe_oe_n <= 1'b1;
    end else begin
      if (serial_fmt & ((fmt_s == `FMT_BYTE_CONT) | frame_on)) begin
        serial_clock_oe_n <= cclk_s;  // R07 R08 R11
      end else begin
        serial_clock_oe_n <= 1'b1;  // R08
      end
      serial_data_oe_n         <= ~(serial_fmt & (state_q == ST_CONV) & ~bit_q);  // R07 R08
      serial_frame_strobe_oe_n <= ~(serial_fmt & frame_on);  // R11 R09
    end
  end
endmodule
`default_nettype wire

/* File: sim/adc_host_interface_sva.sv */
// Pin-level checker for the converter host interface.
// Assumes binding to adc_host_interface, with conv_clk far slower than clk.
`timescale 1ns/10ps
`default_nettype none
module adc_host_interface_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [1:0]  format_select,
  input wire logic        convert_start_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        msb_or_byte_select_pin,
  input wire logic [11:0] data_out,
  input wire logic        data_oe_n,
  input wire logic        busy_int_n,
  input wire logic        serial_clock_oe_n,
  input wire logic        serial_data_oe_n,
  input wire logic        serial_frame_strobe_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] low_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_q <= 8'h00;
    else if (serial_frame_strobe_oe_n) low_q <= 8'h00;
    else low_q <= low_q + 8'h01;
  end
  property p_int_set; $rose(serial_frame_strobe_oe_n) && convert_start_n |-> ##[0:4] !busy_int_n; endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not raised");
  property p_int_clr; $fell(cs_n | rd_n) && convert_start_n && !busy_int_n |-> ##[1:6] busy_int_n; endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt not cleared by read");
  property p_wait_hold; !convert_start_n && !busy_int_n |-> data_oe_n; endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("data driven while busy");
  property p_slow_start;
    !convert_start_n && $fell(cs_n) && !msb_or_byte_select_pin && serial_frame_strobe_oe_n |-> ##[2:8] !busy_int_n;
  endproperty
  a_slow_start: assert property (p_slow_start) else $error("chip select did not start");
  property p_second_fast; !convert_start_n && $fell(cs_n) && msb_or_byte_select_pin && busy_int_n |-> ##[2:8] !data_oe_n;
  endproperty
  a_second_fast: assert property (p_second_fast) else $error("second byte read waited");
  property p_gated_off;
    format_select == 2'h0 && $past(format_select, 8) == 2'h0 && serial_frame_strobe_oe_n
      && $past(serial_frame_strobe_oe_n, 8) |-> (serial_clock_oe_n && serial_data_oe_n)
      or (##[1:3] !serial_frame_strobe_oe_n);
  endproperty
  a_gated_off: assert property (p_gated_off) else $error("serial lines active while idle");
  property p_free_clk; format_select == 2'h1 && $past(format_select, 8) == 2'h1 |-> ##[0:8] $changed(serial_clock_oe_n);
  endproperty
  a_free_clk: assert property (p_free_clk) else $error("serial clock stopped");
  property p_frame_len; $rose(serial_frame_strobe_oe_n) |-> low_q >= 8'h70 && low_q <= 8'h8C; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_hi_nibble; !data_oe_n && format_select != 2'h2 |-> data_out[11:8] == 4'h0; endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("byte read upper bits set");
  c_word: cover property (!data_oe_n && format_select == 2'h2);
  c_slow: cover property (!convert_start_n && !busy_int_n);
  c_cont: cover property (format_select == 2'h1 && !serial_frame_strobe_oe_n);
endmodule
bind adc_host_interface adc_host_interface_sva u_adc_host_interface_sva (.clk(clk), .rst_n(rst_n),
  .format_select(format_select), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
  .msb_or_byte_select_pin(msb_or_byte_select_pin), .data_out(data_out), .data_oe_n(data_oe_n),
  .busy_int_n(busy_int_n), .serial_clock_oe_n(serial_clock_oe_n), .serial_data_oe_n(serial_data_oe_n),
  .serial_frame_strobe_oe_n(serial_frame_strobe_oe_n));
`default_nettype wire

/* File: sim/serial_receiver.sv */
// Host-side serial receiver on the converter's three open-drain lines.
// Assumes pull-ups, so a released line reads high and the pin equals its enable.
`timescale 1ns/10ps
`default_nettype none
module serial_receiver (
  input  wire logic        clk,
  input  wire logic        serial_clock_oe_n,
  input  wire logic        serial_data_oe_n,
  input  wire logic        serial_frame_strobe_oe_n,
  output var  logic [15:0] rx_word = 16'h0000,
  output var  logic [4:0]  rx_count = 5'h00
);
  logic sclk_q = 1'b1;
  logic strb_q = 1'b1;
  // Every fall inside the frame must carry a bit, so the first one is taken without waiting for a rise.
  always @(posedge clk) begin
    sclk_q <= serial_clock_oe_n;
    strb_q <= serial_frame_strobe_oe_n;
    if (strb_q && !serial_frame_strobe_oe_n) begin
      rx_count <= 5'h00;
    end else if (!serial_frame_strobe_oe_n && sclk_q && !serial_clock_oe_n) begin
      rx_word <= {rx_word[14:0], serial_data_oe_n};
      rx_count <= rx_count + 5'h01;
    end
  end
endmodule
`default_nettype wire

/* File: sim/adc_host_interface_tb.sv */
// Self-checking bench for the converter host interface.
// Assumes the serial receiver model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module adc_host_interface_tb;
  logic        clk = 1'b0, rst_n = 1'b0, conv_clk = 1'b0, cs_n = 1'b1, rd_n = 1'b1;
  logic        convert_start_n = 1'b1, msb_or_byte_select_pin = 1'b0;
  logic [1:0]  fmt = 2'h2;
  logic [11:0] code = 12'h000, rd_val;
  logic [11:0] tbl [2] = '{12'h3B7, 12'hFFF};
  wire  [11:0] data_out;
  wire         data_oe_n, busy_int_n, sclk_oe_n, serial_data_pin_oe_n, strb_oe_n;
  wire  [15:0] rx_word;
  wire  [4:0]  rx_count;
  int          err_total = 0, n_tests = 0, i;
  always #25 clk = ~clk;
  initial begin
    #13;
    forever #200 conv_clk = ~conv_clk;
  end
  adc_host_interface u_adc_host_interface (.clk(clk), .rst_n(rst_n), .conv_clk(conv_clk), .format_select(fmt),
    .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n), .msb_or_byte_select_pin(msb_or_byte_select_pin),
    .sample_code(code), .data_out(data_out), .data_oe_n(data_oe_n), .busy_int_n(busy_int_n),
    .serial_clock_oe_n(sclk_oe_n), .serial_data_oe_n(serial_data_pin_oe_n), .serial_frame_strobe_oe_n(strb_oe_n));
  serial_receiver u_serial_receiver (.clk(clk), .serial_clock_oe_n(sclk_oe_n), .serial_data_oe_n(serial_data_pin_oe_n),
    .serial_frame_strobe_oe_n(strb_oe_n), .rx_word(rx_word), .rx_count(rx_count));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hold the strobes until the drive is seen, so the data is taken at that same edge.
  task automatic rd(input logic hb, output logic [11:0] v);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    msb_or_byte_select_pin <= hb;
    for (int k = 0; k < 600 && data_oe_n !== 1'b0; k++) @(posedge clk);
    v = data_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic conv(input logic [1:0] f, input logic [11:0] c);
    fmt <= f;
    code <= c;
    repeat (10) @(posedge clk);
    convert_start_n <= 1'b0;
    repeat (3) @(posedge clk);
    convert_start_n <= 1'b1;
    for (int k = 0; k < 600 && busy_int_n !== 1'b0; k++) @(posedge clk);
    `CHK("int", 1'b0, busy_int_n)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    conv(2'h2, 12'hA5C);
    rd(1'b0, rd_val);
    `CHK("word", 12'hA5C, rd_val)
    `CHK("int_clr", 1'b1, busy_int_n)
    for (i = 0; i < 2; i++) begin
      conv(i[1:0], tbl[i]);
      `CHK("rx_cnt", 5'h10, rx_count)
      `CHK("rx_word", ({4'h0, tbl[i]}), rx_word)
      rd(1'b0, rd_val);
      `CHK("lo", ({4'h0, tbl[i][7:0]}), rd_val)
      rd(1'b1, rd_val);
      `CHK("hi", ({8'h00, tbl[i][11:8]}), rd_val)
    end
    fmt <= 2'h0;
    code <= 12'h801;
    convert_start_n <= 1'b0;
    repeat (10) @(posedge clk);
    rd(1'b0, rd_val);
    `CHK("slow_lo", 12'h001, rd_val)
    rd(1'b1, rd_val);
    `CHK("slow_hi", 12'h008, rd_val)
    `CHK("gated", 1'b1, sclk_oe_n)
    tally_and_finish;
  end
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
